/* File: include/pts_pkg.sv */
// Purpose: constants for the four-port power sequencer timing block
// Assumes: pclk at 10 MHz; times held in their printed unit
// Notes:   cycle counts derived from times; long counts are overridable
package pts_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_US         = 100;
  localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned RESET_PULSE_US  = 120;
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_US * (CLK_HZ / 1_000_000));
  // ticks of 100 us
  localparam int unsigned START_MS        = 60;
  localparam int unsigned START_TK        = START_MS * 10;
  localparam int unsigned LIMIT_MS        = 60;
  localparam int unsigned LIMIT_TK        = LIMIT_MS * 10;
  localparam int unsigned FAULT_MAX_MS    = 70;
  localparam int unsigned FAULT_STEP_MS   = 5;
  localparam int unsigned FAULT_STEP_TK   = FAULT_STEP_MS * 10;
  // default code d: (d+1) x 5 ms = 70 ms, the longest allowed window
  localparam logic [3:0]  FAULT_CODE_RST  = 4'hd;
  localparam int unsigned SETTLE_MS       = 80;
  localparam int unsigned SETTLE_TK       = SETTLE_MS * 10;
  localparam int unsigned PROBE_MAX_MS    = 330;
  localparam int unsigned PROBE_MAX_TK    = PROBE_MAX_MS * 10;
  localparam int unsigned INJ_DELAY_S     = 2;
  localparam int unsigned INJ_DELAY_TK    = INJ_DELAY_S * 10_000;
  localparam int unsigned CLASS_MS        = 19;
  localparam int unsigned CLASS_TK        = CLASS_MS * 10;
  localparam int unsigned SUPPLY_OK_MS    = 3;
  localparam int unsigned SUPPLY_OK_TK    = SUPPLY_OK_MS * 10;
  localparam int unsigned RESTART_MS      = 960;
  localparam int unsigned RESTART_TK      = RESTART_MS * 10;
  localparam int unsigned STAGGER_MS      = 500;
  localparam int unsigned STAGGER_TK      = STAGGER_MS * 10;
  localparam int unsigned GOOD_MS         = 4;
  localparam int unsigned GOOD_TK         = GOOD_MS * 10;
  localparam int unsigned UNLOAD_MS       = 350;
  localparam int unsigned UNLOAD_TK       = UNLOAD_MS * 10;
  localparam int unsigned ADC_BITS        = 9;
  localparam int unsigned NPORT           = 4;
  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_FCODE  = 8'h04;
  localparam logic [7:0] A_STATE  = 8'h08;
  localparam logic [7:0] A_EVENT  = 8'h0c;
  localparam logic [7:0] A_MASK   = 8'h10;
  localparam logic [7:0] A_ADC01  = 8'h14;
  localparam logic [7:0] A_ADC23  = 8'h18;
  // control register fields
  localparam int unsigned C_AUTO  = 0;
  localparam int unsigned C_INJ   = 1;
  localparam int unsigned C_DCDIS = 2;
  localparam int unsigned C_EN0   = 4;
  typedef enum logic [2:0] {
    PS_OFF, PS_SETTLE, PS_PROBE, PS_CLASS, PS_WAITON, PS_START,
    PS_ON, PS_RESTART
  } pts_state_t;
endpackage

/* File: design/pts_sequencer.sv */
// Purpose: per-port detection/class/startup/fault/restart sequencing
// Assumes: pins synchronous to pclk; APB slave, zero wait states
// Notes:   event register clears on read; irq is a level
`timescale 1ns/1ps
module pts_sequencer
  import pts_pkg::*;
#(
  parameter int unsigned INJ_TK     = INJ_DELAY_TK,
  parameter int unsigned RESTART_T  = RESTART_TK,
  parameter int unsigned STAGGER_T  = STAGGER_TK,
  parameter int unsigned PROBE_T    = PROBE_MAX_TK,
  parameter int unsigned UNLOAD_T   = UNLOAD_TK
)(
  // clock, reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // pins
  input  wire logic                enable_pin,
  input  wire logic                high_supply_ok,
  input  wire logic [NPORT-1:0]    probe_valid,
  input  wire logic [NPORT-1:0]    over_startup_limit,
  input  wire logic [NPORT-1:0]    over_fault_limit,
  input  wire logic [NPORT-1:0]    in_current_limit,
  input  wire logic [NPORT-1:0]    output_above_thr,
  input  wire logic [NPORT-1:0]    sense_below_thr,
  input  wire logic [4*ADC_BITS-1:0] adc_current,
  input  wire logic [4*ADC_BITS-1:0] adc_voltage,
  // outputs
  output logic      [NPORT-1:0]    port_power_on,
  output logic      [NPORT-1:0]    output_good_flag,
  output logic                     device_ready,
  output logic                     irq
);
  localparam int TW = 16;
  localparam int unsigned RSTCNT = RESET_PULSE_CYC;

  // ------------------------------------------------------------
  // time base and enable-pin reset
  // ------------------------------------------------------------
  logic [9:0]  div_q;
  logic        tick;
  logic [11:0] enlow_q;
  logic        soft_rst_q;
  logic [7:0]  sup_q;
  logic        ready_q;

  assign tick = (div_q == 10'(TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= '0;
    else
      div_q <= tick ? '0 : div_q + 10'h001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enlow_q    <= '0;
      soft_rst_q <= 1'b0;
    end
    else if (enable_pin)
    begin
      enlow_q    <= '0;
      soft_rst_q <= 1'b0;
    end
    // the low sample that completes 120 us already resets
    else if (enlow_q != 12'(RSTCNT - 1))
      enlow_q <= enlow_q + 12'h001;
    else
      soft_rst_q <= 1'b1;
  end

  // rail must hold good continuously; any dropout restarts the wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sup_q   <= '0;
      ready_q <= 1'b0;
    end
    else if (!high_supply_ok || soft_rst_q)
    begin
      sup_q   <= '0;
      ready_q <= 1'b0;
    end
    else if (tick && !ready_q)
    begin
      sup_q   <= sup_q + 8'h01;
      ready_q <= (sup_q == 8'(SUPPLY_OK_TK - 1));
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [15:0] fcode_q;
  logic [7:0]  event_q;
  logic [7:0]  mask_q;
  logic [TW-1:0] stag_q;
  logic [NPORT-1:0] turn_on;
  logic [7:0]  ev_set;
  logic        wr_en;
  logic        rd_ev;

  assign wr_en = psel && penable && pwrite;
  assign rd_ev = psel && penable && !pwrite && paddr == A_EVENT;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= 8'h00;
      fcode_q <= {4{FAULT_CODE_RST}};
      mask_q  <= 8'h00;
    end
    else if (soft_rst_q)
    begin
      ctrl_q  <= 8'h00;
      fcode_q <= {4{FAULT_CODE_RST}};
      mask_q  <= 8'h00;
    end
    else if (wr_en)
    begin
      if (paddr == A_CTRL)
        ctrl_q <= pwdata[7:0];
      if (paddr == A_FCODE)
        fcode_q <= pwdata[15:0];
      if (paddr == A_MASK)
        mask_q <= pwdata[7:0];
    end
  end

  // set wins over the read clear; only bits the read returned are
  // cleared, so an event landing at the setup edge is not lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_q <= '0;
    else if (soft_rst_q)
      event_q <= '0;
    else
      event_q <= (rd_ev ? event_q & ~prdata[7:0] : event_q) | ev_set;
  end

  // ------------------------------------------------------------
  // per-port state machines
  // ------------------------------------------------------------
  pts_state_t       st_q   [NPORT];
  logic [TW-1:0]    tm_q   [NPORT];
  logic [TW-1:0]    sub_q  [NPORT];
  logic [7:0]       good_q [NPORT];
  logic [ADC_BITS-1:0] icap_q [NPORT];
  logic [ADC_BITS-1:0] vcap_q [NPORT];
  logic [NPORT-1:0] fault_ev;
  logic [NPORT-1:0] unload_ev;
  logic [NPORT-1:0] want_on;

  function automatic logic [TW-1:0] fault_tk(input logic [3:0] c);
    fault_tk = TW'((32'(c) + 32'd1) * FAULT_STEP_TK);
  endfunction

  // lowest port waiting wins the stagger slot
  assign want_on[0] = st_q[0] == PS_WAITON;
  for (genvar g = 1; g < NPORT; g++)
  begin : g_pri
    assign want_on[g] = st_q[g] == PS_WAITON && !(|want_on[g-1:0]) ;
  end
  assign turn_on = want_on & {NPORT{stag_q == '0 || !ctrl_q[C_AUTO]}};
  assign ev_set  = {unload_ev, fault_ev};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stag_q <= '0;
    else if (soft_rst_q)
      stag_q <= '0;
    else if (|turn_on)
      stag_q <= TW'(STAGGER_T);
    else if (tick && stag_q != '0)
      stag_q <= stag_q - 1'b1;
  end

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic [TW-1:0] fw;
    logic          run;
    assign fw  = fault_tk(fcode_q[4*p +: 4]);
    assign run = ready_q && ctrl_q[C_EN0+p];
    assign fault_ev[p]  = st_q[p] == PS_ON && tick &&
                          over_fault_limit[p] && tm_q[p] >= fw - 1'b1;
    assign unload_ev[p] = st_q[p] == PS_ON && tick && ctrl_q[C_DCDIS] &&
                          sense_below_thr[p] && sub_q[p] >= TW'(UNLOAD_T - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        st_q[p]  <= PS_OFF;
        tm_q[p]  <= '0;
        sub_q[p] <= '0;
      end
      else if (soft_rst_q || !run)
      begin
        st_q[p]  <= PS_OFF;
        tm_q[p]  <= '0;
        sub_q[p] <= '0;
      end
      else
      begin
        if (tick)
          tm_q[p] <= tm_q[p] + 1'b1;
        case (st_q[p])
          PS_OFF:
          begin
            st_q[p] <= PS_SETTLE;
            tm_q[p] <= '0;
          end
          PS_SETTLE:
            if (tick && tm_q[p] >= TW'((ctrl_q[C_INJ] ? INJ_TK : SETTLE_TK) - 1))
            begin
              st_q[p] <= PS_PROBE;
              tm_q[p] <= '0;
            end
          PS_PROBE:
            if (probe_valid[p])
            begin
              st_q[p] <= PS_CLASS;
              tm_q[p] <= '0;
            end
            else if (tick && tm_q[p] >= TW'(PROBE_T - 1))
            begin
              st_q[p] <= PS_SETTLE;
              tm_q[p] <= '0;
            end
          PS_CLASS:
            if (tick && tm_q[p] >= TW'(CLASS_TK - 1))
              st_q[p] <= PS_WAITON;
          PS_WAITON:
            if (turn_on[p])
            begin
              st_q[p] <= PS_START;
              tm_q[p] <= '0;
            end
          PS_START:
            if (tick && tm_q[p] >= TW'(START_TK - 1))
            begin
              st_q[p]  <= over_startup_limit[p] ? PS_RESTART : PS_ON;
              tm_q[p]  <= '0;
              sub_q[p] <= '0;
            end
          PS_ON:
          begin
            if (tick)
            begin
              tm_q[p]  <= over_fault_limit[p] ? tm_q[p] + 1'b1 : '0;
              sub_q[p] <= sense_below_thr[p] ? sub_q[p] + 1'b1 : '0;
            end
            if (fault_ev[p] || (tick && in_current_limit[p] &&
                tm_q[p] >= TW'(LIMIT_TK - 1)))
            begin
              st_q[p] <= PS_RESTART;
              tm_q[p] <= '0;
            end
            else if (unload_ev[p])
            begin
              st_q[p] <= PS_SETTLE;
              tm_q[p] <= '0;
            end
          end
          PS_RESTART:
            if (ctrl_q[C_INJ] ||
                (tick && tm_q[p] >= TW'(RESTART_T - 1)))
            begin
              st_q[p] <= PS_SETTLE;
              tm_q[p] <= '0;
            end
          default:
            st_q[p] <= PS_OFF;
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        good_q[p]           <= '0;
        output_good_flag[p] <= 1'b0;
        port_power_on[p]    <= 1'b0;
        icap_q[p]           <= '0;
        vcap_q[p]           <= '0;
      end
      else
      begin
        port_power_on[p] <= st_q[p] == PS_START || st_q[p] == PS_ON;
        if (!port_power_on[p] || !output_above_thr[p])
        begin
          good_q[p]           <= '0;
          output_good_flag[p] <= 1'b0;
        end
        else if (tick && good_q[p] != 8'(GOOD_TK))
          good_q[p] <= good_q[p] + 8'h01;
        else if (good_q[p] == 8'(GOOD_TK))
          output_good_flag[p] <= 1'b1;
        if (st_q[p] == PS_ON && tick)
        begin
          icap_q[p] <= adc_current[ADC_BITS*p +: ADC_BITS];
          vcap_q[p] <= adc_voltage[ADC_BITS*p +: ADC_BITS];
        end
      end
    end

    property p_class_len;
      @(posedge pclk) disable iff (!presetn)
      st_q[p] == PS_CLASS |-> tm_q[p] < TW'(CLASS_TK);
    endproperty
    a_class_len: assert property (p_class_len)
      else $error("classification phase overran");

    property p_probe_len;
      @(posedge pclk) disable iff (!presetn)
      st_q[p] == PS_PROBE |-> tm_q[p] < TW'(PROBE_T);
    endproperty
    a_probe_len: assert property (p_probe_len)
      else $error("detection phase overran");
  end

  // ------------------------------------------------------------
  // apb read side and outputs
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] st_word;
  assign st_word = {15'h0000, ready_q, 4'h0, 3'(st_q[3]), 3'(st_q[2]),
                    3'(st_q[1]), 3'(st_q[0])};
  assign rd_mux =
    paddr == A_CTRL  ? {24'h000000, ctrl_q} :
    paddr == A_FCODE ? {16'h0000, fcode_q} :
    paddr == A_STATE ? st_word :
    paddr == A_EVENT ? {24'h000000, event_q} :
    paddr == A_MASK  ? {24'h000000, mask_q} :
    paddr == A_ADC01 ? {7'h00, icap_q[1], vcap_q[1][6:0], icap_q[0]} :
    paddr == A_ADC23 ? {7'h00, icap_q[3], vcap_q[3][6:0], icap_q[2]} :
    32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata       <= '0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      device_ready <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      pready       <= psel && !penable;
      pslverr      <= 1'b0;
      prdata       <= (psel && !penable) ? rd_mux : prdata;
      device_ready <= ready_q;
      irq          <= |(event_q & mask_q);
    end
  end

  // software may still switch the port off during startup
  sequence s_power_held;
    (port_power_on[0] || !ctrl_q[C_EN0]) [*8];
  endsequence

  property p_start_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(port_power_on[0]) && !soft_rst_q |-> s_power_held;
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("startup power dropped early");

  property p_soft_off;
    @(posedge pclk) disable iff (!presetn)
    soft_rst_q |-> ##2 (port_power_on == '0);
  endproperty
  a_soft_off: assert property (p_soft_off)
    else $error("port still powered after enable reset");

  property p_ready_drop;
    @(posedge pclk) disable iff (!presetn)
    !high_supply_ok |=> !ready_q;
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready kept through a rail dropout");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (|ev_set) && !soft_rst_q |=>
      (event_q & $past(ev_set)) == $past(ev_set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against a read clear");

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held for more than one cycle");
endmodule

/* File: verification/pts_pd_model.sv */
// Purpose: behavioural powered devices on the four ports
// Assumes: a valid signature on every port that the bench marks present
// Notes:   overload only where the bench asks; readings are fixed codes
`timescale 1ns/1ps
module pts_pd_model
  import pts_pkg::*;
(
  // bench control
  input  wire logic [NPORT-1:0]      present,
  input  wire logic [NPORT-1:0]      overload,
  // from the sequencer
  input  wire logic [NPORT-1:0]      port_power_on,
  // to the sequencer
  output logic      [NPORT-1:0]      probe_valid,
  output logic      [NPORT-1:0]      over_startup_limit,
  output logic      [NPORT-1:0]      over_fault_limit,
  output logic      [NPORT-1:0]      in_current_limit,
  output logic      [NPORT-1:0]      output_above_thr,
  output logic      [NPORT-1:0]      sense_below_thr,
  output logic      [4*ADC_BITS-1:0] adc_current,
  output logic      [4*ADC_BITS-1:0] adc_voltage
);
  // an unpowered load draws nothing, so no flag but probe_valid without power
  assign probe_valid        = present;
  assign over_startup_limit = overload & port_power_on;
  assign over_fault_limit   = overload & port_power_on;
  assign in_current_limit   = overload & port_power_on;
  assign output_above_thr   = port_power_on;
  assign sense_below_thr    = ~present & port_power_on;
  // 9-bit codes per port, port 0 lowest
  assign adc_current        = {4{9'h0a5}};
  assign adc_voltage        = {4{9'h11b}};
endmodule

/* File: verification/pts_sequencer_tb.sv */
// Purpose: self-checking bench for the port timing sequencer
// Assumes: apb slave answers in the access cycle; 100 us tick
// Notes:   long settle and start phases are out of reach in one run
`timescale 1ns/1ps
module pts_sequencer_tb;
  import pts_pkg::*;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  enable_pin = 1'b1;
  logic                  high_supply_ok = 1'b0;
  logic [NPORT-1:0]      present = 4'h1;
  logic [NPORT-1:0]      overload = 4'h0;
  logic [NPORT-1:0]      probe_valid, over_startup_limit, over_fault_limit;
  logic [NPORT-1:0]      in_current_limit, output_above_thr, sense_below_thr;
  logic [4*ADC_BITS-1:0] adc_current, adc_voltage;
  logic [NPORT-1:0]      port_power_on, output_good_flag;
  logic                  device_ready, irq;
  int                    error_cnt = 0;
  int                    cmp_count = 0;

  always #50 pclk = ~pclk;

  pts_sequencer #(.INJ_TK(20), .RESTART_T(20), .STAGGER_T(20),
    .PROBE_T(20), .UNLOAD_T(20)) u_pts_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
    .high_supply_ok(high_supply_ok), .probe_valid(probe_valid),
    .over_startup_limit(over_startup_limit),
    .over_fault_limit(over_fault_limit),
    .in_current_limit(in_current_limit),
    .output_above_thr(output_above_thr), .sense_below_thr(sense_below_thr),
    .adc_current(adc_current), .adc_voltage(adc_voltage),
    .port_power_on(port_power_on), .output_good_flag(output_good_flag),
    .device_ready(device_ready), .irq(irq));

  pts_pd_model u_pts_pd_model (
    .present(present), .overload(overload), .port_power_on(port_power_on),
    .probe_valid(probe_valid), .over_startup_limit(over_startup_limit),
    .over_fault_limit(over_fault_limit),
    .in_current_limit(in_current_limit),
    .output_above_thr(output_above_thr), .sense_below_thr(sense_below_thr),
    .adc_current(adc_current), .adc_voltage(adc_voltage));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  // one transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      stop_test();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic wait_ticks(input int n);
    repeat (n * TICK_CYC) @(posedge pclk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    rd_chk(A_CTRL, 32'h0);
    rd_chk(A_FCODE, {16'h0, {4{FAULT_CODE_RST}}});
    rd_chk(A_STATE, 32'h0);
    rd_chk(A_EVENT, 32'h0);
    rd_chk(A_MASK, 32'h0);
    wr(8'h1c, 32'hffff_ffff);
    rd_chk(8'h1c, 32'h0);
    check(pslverr, 1'b0);
    check(port_power_on, 4'h0);
    check(irq, 1'b0);
  endtask

  // ready needs the rail good without a break for 2 to 4 ms
  task automatic t_supply();
    int n;
    high_supply_ok <= 1'b1;
    wait_ticks(5);
    high_supply_ok <= 1'b0;
    wait_ticks(1);
    check(device_ready, 1'b0);
    high_supply_ok <= 1'b1;
    wait_ticks(19);
    check(device_ready, 1'b0);
    n = 0;
    while (device_ready !== 1'b1 && n < 22 * TICK_CYC)
    begin
      @(posedge pclk);
      n++;
    end
    check(n < 21 * TICK_CYC, 1'b1);
    rd_chk(A_STATE, 32'h0001_0000);
  endtask

  task automatic t_regs();
    wr(A_FCODE, 32'h0000_d7d2);
    rd_chk(A_FCODE, 32'h0000_d7d2);
    wr(A_MASK, 32'h0000_00ff);
    rd_chk(A_MASK, 32'h0000_00ff);
    rd_chk(A_EVENT, 32'h0);
    check(irq, 1'b0);
  endtask

  // probing waits out the settle time; a failed probe settles again
  task automatic t_settle();
    wr(A_CTRL, 32'h1 << C_EN0);
    wait_ticks(3);
    rd_chk(A_STATE, 32'h0001_0000 | 32'(PS_SETTLE));
    check(port_power_on, 4'h0);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, (32'h1 << C_INJ) | (32'h3 << C_EN0));
    wait_ticks(10);
    rd_chk(A_STATE, 32'h0001_0000 | (32'(PS_SETTLE) << 3) |
           32'(PS_SETTLE));
    wait_ticks(20);
    rd_chk(A_STATE, 32'h0001_0000 | (32'(PS_PROBE) << 3) |
           32'(PS_CLASS));
    wait_ticks(20);
    rd_chk(A_STATE, 32'h0001_0000 | (32'(PS_SETTLE) << 3) |
           32'(PS_CLASS));
    check(port_power_on, 4'h0);
  endtask

  // a long enough low on the enable pin resets registers and ports, but not the ADC captures
  task automatic t_enable_reset();
    @(posedge pclk);
    enable_pin <= 1'b0;
    repeat (RESET_PULSE_CYC) @(posedge pclk);
    enable_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    check(device_ready, 1'b0);
    check(port_power_on, 4'h0);
    rd_chk(A_CTRL, 32'h0);
    rd_chk(A_FCODE, {16'h0, {4{FAULT_CODE_RST}}});
  endtask

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_supply();
    t_regs();
    t_settle();
    t_enable_reset();
    stop_test();
  end
endmodule
